/* inc/mnh_pkg.sv */
// Constants and types for the mesh node command handler
// Assumes one clock domain at 250 MHz and a 32-bit register bus
package mnh_pkg;
    localparam int unsigned CLK_MHZ  = 250;
    localparam int unsigned TICK_US  = 1000;
    localparam int unsigned MS_CYC   = CLK_MHZ * TICK_US;
    localparam int unsigned AXI_AW   = 12;
    localparam int unsigned DATA_MAX = 256;
    localparam int unsigned RXB_N    = 40;
    localparam int unsigned CFG_N    = 64;
    localparam int unsigned GRP_N    = 8;
    localparam int unsigned GPIO_N   = 8;
    localparam int unsigned PAIR_N   = 16;
    localparam int unsigned RPL_N    = 20;
    // Command byte positions, zero based
    localparam int unsigned B_LEN = 0, B_DST = 1, B_TAG = 5, B_TYPE = 6;
    localparam int unsigned B_CODE = 7, B_D1 = 8, B_D2 = 9;
    // Reply byte positions, zero based
    localparam int unsigned P_NET = 1, P_NODE = 5, P_TYPE = 16;
    localparam int unsigned P_DET = 17, P_MSB = 18, P_LSB = 19;
    localparam logic [7:0] LEN_CTRL = 8'h0A, LEN_CFG = 8'h28, RPL_LEN = 8'h14;
    localparam logic [7:0] PT_CMD = 8'h03, PT_EVT = 8'h02, ALL1 = 8'hFF;
    localparam logic [7:0] EVT_ACK = 8'h10, EVT_NAK = 8'h11;
    localparam logic [7:0] C_SET = 8'h01, C_PWM = 8'h02, C_CFGW = 8'h03;
    localparam logic [7:0] C_CFGM = 8'h05, C_TOG = 8'h08, C_QLO = 8'h10;
    localparam logic [7:0] C_QHI = 8'h14, C_RST = 8'h15, C_PATH = 8'h16;
    localparam logic [7:0] PWM_MAX = 8'h64;
    localparam logic [7:0] RSN_NONE = 8'h00, RSN_CODE = 8'h01, RSN_RANGE = 8'h02;
    localparam logic [7:0] RSN_LEN = 8'h03, RSN_LOCK = 8'h04;
    // Configuration memory map
    localparam logic [7:0] CA_CHAN = 8'h01, CA_RATE = 8'h02, CA_NODE = 8'h04;
    localparam logic [7:0] CA_NET = 8'h08, CA_GRP = 8'h10, CA_GPIO = 8'h18;
    localparam logic [7:0] CA_GAP = 8'h20, FN_OUT = 8'h01;
    localparam logic [31:0] NET_DFLT = 32'h0000_0000;
    // Register offsets and control bits
    localparam logic [11:0] A_CTRL = 12'h000, A_STAT = 12'h004, A_OUT = 12'h008;
    localparam logic [3:0] A_CFG_HI = 4'h1;
    localparam int unsigned CB_GW = 0, CB_ACK = 1, CB_HS = 2;
    localparam logic [1:0] RESP_OK = 2'b00, RESP_ERR = 2'b10;
    typedef enum logic [1:0] {
        ST_COLLECT = 2'b00,
        ST_CHECK   = 2'b01,
        ST_CFGW    = 2'b10,
        ST_REPLY   = 2'b11
    } mnh_state_e;
endpackage

/* design/mnh_node_cmd.sv */
// Packet framing, address filter, command check and execution, event reply
// Assumes serial and mesh bytes arrive on aclk from neighbouring logic
//
// The register addresses and register access over AXI4-Lite were decided locally.
`timescale 1ns/100ps
module mnh_node_cmd #(
    parameter int unsigned MS_CYCLES = mnh_pkg::MS_CYC
) (
    input  wire  logic                        aclk,
    input  wire  logic                        aresetn,
    input  wire  logic [mnh_pkg::AXI_AW-1:0]  awaddr,
    input  wire  logic                        awvalid,
    output logic                              awready,
    input  wire  logic [31:0]                 wdata,
    input  wire  logic [3:0]                  wstrb,
    input  wire  logic                        wvalid,
    output logic                              wready,
    output logic [1:0]                        bresp,
    output logic                              bvalid,
    input  wire  logic                        bready,
    input  wire  logic [mnh_pkg::AXI_AW-1:0]  araddr,
    input  wire  logic                        arvalid,
    output logic                              arready,
    output logic [31:0]                       rdata,
    output logic [1:0]                        rresp,
    output logic                              rvalid,
    input  wire  logic                        rready,
    input  wire  logic                        ser_valid,
    input  wire  logic [7:0]                  ser_byte,
    input  wire  logic                        net_valid,
    input  wire  logic [7:0]                  net_byte,
    input  wire  logic                        net_last,
    output logic                              tx_valid,
    output logic [7:0]                        tx_byte,
    input  wire  logic                        tx_ready,
    output logic                              data_valid,
    output logic [7:0]                        data_byte,
    output logic                              data_end,
    output logic [mnh_pkg::GPIO_N-1:0]        gpio_out,
    output logic [mnh_pkg::GPIO_N-1:0]        gpio_oe,
    output logic [7:0]                        pwm_duty,
    output logic                              cfg_mode_req,
    output logic                              reset_req,
    output logic                              query_req,
    output logic [7:0]                        query_code
);
    import mnh_pkg::*;
    localparam int unsigned MSW = $clog2(MS_CYCLES);

    mnh_state_e     st;
    mnh_state_e     next_st;
    logic [7:0]     rxb [RXB_N];
    logic [7:0]     cfg [CFG_N];
    logic [7:0]     cnt;
    logic [2:0]     ctrl;
    logic [MSW-1:0] fr_cnt;
    logic [MSW-1:0] gp_cnt;
    logic [8:0]     gap_ms;
    logic           gap_seen;
    logic [8:0]     dcnt;
    logic [7:0]     lvl;
    logic [7:0]     tmask;
    logic [7:0]     tms;
    logic [3:0]     pi;
    logic           rpl_q;
    logic           ack_q;
    logic [7:0]     rsn_q;
    logic [7:0]     drops;
    logic [4:0]     tx_pos;
    logic [PAIR_N-1:0] pv;
    logic           bad_rng;
    logic           bad_lock;
    logic           grp_hit;
    logic [7:0]     rb;
    logic           aw_got;
    logic           w_got;
    logic [AXI_AW-1:0] waddr;
    logic [31:0]    wdat;
    logic [3:0]     wstb;

    ////////////////////////////////////////////////////////////////////////
    // Millisecond ticks and serial gap timer
    wire fr_tick = fr_cnt == MSW'(MS_CYCLES - 1);
    wire gp_tick = gp_cnt == MSW'(MS_CYCLES - 1);
    wire [8:0] gap_lim = {1'b0, cfg[CA_GAP[5:0]]};
    wire gap_exp = gap_ms > gap_lim;
    wire gap_hit = gap_exp && !gap_seen;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fr_cnt   <= '0;
            gp_cnt   <= '0;
            gap_ms   <= '0;
            gap_seen <= 1'b1;
        end else begin
            fr_cnt   <= fr_tick ? '0 : fr_cnt + 1'b1;
            gp_cnt   <= (ser_valid || gp_tick) ? '0 : gp_cnt + 1'b1;
            gap_ms   <= ser_valid ? '0 : gap_ms + 9'(gp_tick && !(&gap_ms));
            gap_seen <= !ser_valid && (gap_seen || gap_exp);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Frame collection
    wire       gw   = ctrl[CB_GW];
    wire       in_v = gw ? ser_valid : net_valid;
    wire [7:0] in_b = gw ? ser_byte : net_byte;
    wire       f_end = gw ? (gap_hit && cnt != 8'h00) : (net_valid && net_last);
    wire       col  = st == ST_COLLECT;

    always_ff @(posedge aclk) begin
        if (col && in_v && cnt < 8'(RXB_N))
            rxb[cnt[5:0]] <= in_b;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || !col)
            cnt <= '0;
        else if (in_v && cnt != ALL1)
            cnt <= cnt + 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////
    // Address filter
    wire [31:0] dst  = {rxb[B_DST], rxb[B_DST+1], rxb[B_DST+2], rxb[B_DST+3]};
    wire [31:0] node = {cfg[4], cfg[5], cfg[6], cfg[7]};
    wire [31:0] net  = {cfg[8], cfg[9], cfg[10], cfg[11]};
    wire top3  = dst[31:8] == {ALL1, ALL1, ALL1};
    wire is_bc = top3 && dst[7:0] == ALL1;
    wire own   = dst == node;
    wire multi = top3 && !own;
    wire hit   = gw ? (own || node == '0)
                    : (own || is_bc || (top3 && grp_hit));

    always_comb begin
        grp_hit = 1'b0;
        for (int g = 0; g < GRP_N; g++)
            if (cfg[CA_GRP[5:0] + 6'(g)] == dst[7:0] && dst[7:0] != 8'h00)
                grp_hit = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////
    // Command check
    wire [7:0] code = rxb[B_CODE];
    wire [7:0] d1   = rxb[B_D1];
    wire [7:0] d2   = rxb[B_D2];
    wire [7:0] tag  = rxb[B_TAG];
    wire len_ok = rxb[B_LEN] == cnt && cnt <= 8'(RXB_N);
    wire frm_ok = len_ok && rxb[B_TYPE] == PT_CMD && hit;
    wire is_q   = (code >= C_QLO && code <= C_QHI) || code == C_PATH;
    wire is_cfg = code == C_CFGW;
    wire is_ctl = code == C_SET || code == C_PWM || code == C_CFGM
               || code == C_TOG || code == C_RST || is_q;
    wire unlocked = net == NET_DFLT;

    always_comb begin
        logic       run;
        logic [7:0] a;
        a        = 8'h00;
        run      = 1'b1;
        bad_rng  = 1'b0;
        bad_lock = 1'b0;
        for (int j = 0; j < PAIR_N; j++) begin
            a = rxb[B_D1 + 2*j];
            if (a == 8'h00)
                run = 1'b0;
            pv[j] = run;
            if (run && a >= 8'(CFG_N))
                bad_rng = 1'b1;
            if (run && !unlocked && (a == CA_CHAN || a == CA_RATE
                    || (a >= CA_NODE && a < CA_GRP)))
                bad_lock = 1'b1;
        end
    end

    wire [7:0] rsn = (!is_ctl && !is_cfg) ? RSN_CODE
                   : (rxb[B_LEN] != (is_cfg ? LEN_CFG : LEN_CTRL)) ? RSN_LEN
                   : ((code == C_PWM && d1 > PWM_MAX) || (is_cfg && bad_rng)) ? RSN_RANGE
                   : (is_cfg && bad_lock) ? RSN_LOCK
                   : RSN_NONE;
    wire rpl_want = gw ? ctrl[CB_HS]
                       : ctrl[CB_ACK] && (!multi || tag[7]);
    wire chk = st == ST_CHECK;
    wire exe = chk && frm_ok && rsn == RSN_NONE;

    ////////////////////////////////////////////////////////////////////////
    // Sequencer
    wire tx_go = tx_valid && tx_ready;

    always_comb begin
        next_st = st;
        unique case (st)
            ST_COLLECT: if (f_end) next_st = ST_CHECK;
            ST_CHECK: begin
                if (!frm_ok)
                    next_st = ST_COLLECT;
                else if (exe && is_cfg)
                    next_st = ST_CFGW;
                else
                    next_st = rpl_want ? ST_REPLY : ST_COLLECT;
            end
            ST_CFGW: if (pi == 4'(PAIR_N - 1)) next_st = rpl_q ? ST_REPLY : ST_COLLECT;
            ST_REPLY: if (tx_go && tx_pos == 5'(RPL_N - 1)) next_st = ST_COLLECT;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st    <= ST_COLLECT;
            pi    <= '0;
            rpl_q <= 1'b0;
            ack_q <= 1'b0;
            rsn_q <= RSN_NONE;
            drops <= '0;
        end else begin
            st <= next_st;
            pi <= (st == ST_CFGW) ? pi + 1'b1 : '0;
            if (chk) begin
                rpl_q <= rpl_want;
                ack_q <= rsn == RSN_NONE;
                rsn_q <= rsn;
                drops <= drops + 8'(!frm_ok);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Execution
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lvl          <= '0;
            pwm_duty     <= '0;
            tmask        <= '0;
            tms          <= '0;
            cfg_mode_req <= 1'b0;
            reset_req    <= 1'b0;
            query_req    <= 1'b0;
            query_code   <= '0;
            gpio_out     <= '0;
        end else begin
            if (exe && code == C_SET)
                lvl <= (lvl & ~d2) | d1;
            if (exe && code == C_PWM)
                pwm_duty <= d1;
            if (exe && code == C_TOG) begin
                tmask <= d1;
                tms   <= d2;
            end else if (fr_tick && tms != 8'h00) begin
                tms <= tms - 1'b1;
            end
            cfg_mode_req <= exe && code == C_CFGM;
            reset_req    <= exe && code == C_RST;
            query_req    <= exe && is_q;
            if (exe && is_q)
                query_code <= code;
            gpio_out <= lvl | (tms != 8'h00 ? tmask : 8'h00);
        end
    end

    for (genvar gb = 0; gb < GPIO_N; gb++) begin : g_oe
        always_ff @(posedge aclk) begin
            if (!aresetn)
                gpio_oe[gb] <= 1'b0;
            else
                gpio_oe[gb] <= cfg[CA_GPIO[5:0] + 6'(gb)] == FN_OUT;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Remote serial data path
    wire dfull = dcnt == 9'(DATA_MAX - 1);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            data_valid <= 1'b0;
            data_byte  <= '0;
            data_end   <= 1'b0;
            dcnt       <= '0;
        end else begin
            data_valid <= !gw && ser_valid;
            data_byte  <= ser_byte;
            data_end   <= !gw && ((ser_valid && dfull) || (gap_hit && dcnt != '0));
            if (gw || (ser_valid && dfull) || gap_hit)
                dcnt <= '0;
            else if (ser_valid)
                dcnt <= dcnt + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Reply stream
    wire        rpl_start = next_st == ST_REPLY && st != ST_REPLY;
    wire [4:0]  np = rpl_start ? 5'd0 : tx_pos + 1'b1;
    wire [63:0] hdr = {net, node};

    always_comb begin
        rb = 8'h00;
        if (np == 5'd0)
            rb = RPL_LEN;
        else if (np >= 5'(P_NET) && np < 5'(P_NODE + 4))
            rb = hdr[8*(9 - int'(np)) - 1 -: 8];
        else if (np == 5'(P_TYPE))
            rb = PT_EVT;
        else if (np == 5'(P_DET))
            rb = ack_q ? EVT_ACK : EVT_NAK;
        else if (np == 5'(P_MSB))
            rb = tag;
        else if (np == 5'(P_LSB))
            rb = rsn_q;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_valid <= 1'b0;
            tx_byte  <= '0;
            tx_pos   <= '0;
        end else if (rpl_start || (tx_go && tx_pos != 5'(RPL_N - 1))) begin
            tx_valid <= 1'b1;
            tx_byte  <= rb;
            tx_pos   <= np;
        end else if (tx_go) begin
            tx_valid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register bus slave
    wire aw_hs  = awvalid && awready;
    wire w_hs   = wvalid && wready;
    wire ar_hs  = arvalid && arready;
    wire wr_do  = aw_got && w_got && !bvalid;
    wire w_ctrl = waddr == A_CTRL;
    wire w_cfg  = waddr[11:8] == A_CFG_HI && waddr[1:0] == 2'b00;
    wire r_cfg  = araddr[11:8] == A_CFG_HI && araddr[1:0] == 2'b00;
    wire r_ok   = r_cfg || araddr == A_CTRL || araddr == A_STAT || araddr == A_OUT;
    wire [31:0] rmux = r_cfg ? {24'h0, cfg[araddr[7:2]]}
                     : araddr == A_CTRL ? {29'h0, ctrl}
                     : araddr == A_STAT ? {14'h0, st, drops, rsn_q}
                     : araddr == A_OUT ? {8'h0, gpio_oe, pwm_duty, gpio_out}
                     : 32'h0;
    wire next_awg = (aw_got && !wr_do) || aw_hs;
    wire next_wg  = (w_got && !wr_do) || w_hs;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got  <= 1'b0;
            w_got   <= 1'b0;
            awready <= 1'b0;
            wready  <= 1'b0;
            bvalid  <= 1'b0;
            bresp   <= RESP_OK;
            arready <= 1'b0;
            rvalid  <= 1'b0;
            rdata   <= '0;
            rresp   <= RESP_OK;
            ctrl    <= '0;
        end else begin
            aw_got  <= next_awg;
            w_got   <= next_wg;
            awready <= !next_awg;
            wready  <= !next_wg;
            if (wr_do) begin
                bvalid <= 1'b1;
                bresp  <= (w_ctrl || w_cfg) ? RESP_OK : RESP_ERR;
            end else if (bready) begin
                bvalid <= 1'b0;
            end
            if (wr_do && w_ctrl && wstb[0])
                ctrl <= wdat[2:0];
            arready <= !(ar_hs || (rvalid && !rready));
            if (ar_hs) begin
                rvalid <= 1'b1;
                rdata  <= rmux;
                rresp  <= r_ok ? RESP_OK : RESP_ERR;
            end else if (rready) begin
                rvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (aw_hs)
            waddr <= awaddr;
        if (w_hs) begin
            wdat <= wdata;
            wstb <= wstrb;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Configuration memory, command write beats bus write
    wire [7:0] pa = rxb[B_D1 + 2*int'(pi)];
    wire [7:0] pd = rxb[B_D1 + 2*int'(pi) + 1];

    for (genvar gi = 0; gi < CFG_N; gi++) begin : g_cfg
        wire cw = st == ST_CFGW && pv[pi] && pa[5:0] == 6'(gi);
        wire bw = wr_do && w_cfg && wstb[0] && waddr[7:2] == 6'(gi);
        always_ff @(posedge aclk) begin
            if (!aresetn)
                cfg[gi] <= 8'h00;
            else if (cw)
                cfg[gi] <= pd;
            else if (bw)
                cfg[gi] <= wdat[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_gap_close: assert property (col && gw && gap_hit && cnt != 8'h00 |=> st == ST_CHECK)
        else $error("gap did not close frame");
    a_len_drop: assert property (chk && !len_ok |=> col && $stable(pwm_duty) && !tx_valid)
        else $error("bad length frame used");
    a_multi_quiet: assert property (chk && !gw && multi && !tag[7] |=> !rpl_q && st != ST_REPLY)
        else $error("multicast reply without tag");
    a_nak_hold: assert property (chk && rsn != RSN_NONE
                                 |=> $stable(pwm_duty) && $stable(lvl) && !query_req)
        else $error("rejected command executed");
    a_evt_type: assert property (tx_valid && tx_pos == 5'(P_TYPE) |-> tx_byte == PT_EVT)
        else $error("reply type wrong");
    a_evt_detail: assert property (tx_valid && tx_pos == 5'(P_DET)
                                   |-> tx_byte == (ack_q ? EVT_ACK : EVT_NAK))
        else $error("reply detail wrong");
    a_tag_echo: assert property (tx_valid && tx_pos == 5'(P_MSB) |-> tx_byte == tag)
        else $error("reply tag wrong");
    a_reply_end: assert property (tx_go && tx_pos == 5'(P_LSB) |=> !tx_valid ##1 !tx_valid)
        else $error("reply longer than low byte");
    a_data_cap: assert property (!gw && ser_valid && dfull |=> data_valid && data_end)
        else $error("full buffer not sent");
    a_pwm_limit: assert property (pwm_duty <= PWM_MAX)
        else $error("duty above limit");
    a_oe_reset: assert property ($rose(aresetn) |-> gpio_oe == '0)
        else $error("gpio driven after reset");

    c_ack_reply: cover property (tx_go && tx_pos == 5'(P_DET) && tx_byte == EVT_ACK);
    c_nak_reply: cover property (tx_go && tx_pos == 5'(P_DET) && tx_byte == EVT_NAK);
    c_cfg_walk: cover property (st == ST_CFGW && pv[pi] ##1 st == ST_CFGW);
    c_data_full: cover property (data_end && data_valid);
endmodule

/* test/mnh_host_model.sv */
// Host controller model on the gateway serial port
// Assumes bytes and replies move on aclk
`timescale 1ns/100ps
module mnh_host_model (
    input  wire logic       aclk,
    output logic            ser_valid,
    output logic [7:0]      ser_byte,
    output logic            tx_ready
);
    initial begin
        ser_valid = 1'b0;
        ser_byte  = 8'h00;
        tx_ready  = 1'b0;
    end
    // Slow reply taker
    always @(posedge aclk) tx_ready <= ~tx_ready;
    // One contiguous burst; line scrambled when idle
    task automatic send(input logic [7:0] b[$]);
        foreach (b[i]) begin
            @(posedge aclk);
            ser_valid <= 1'b1;
            ser_byte  <= b[i];
        end
        @(posedge aclk);
        ser_valid <= 1'b0;
        ser_byte  <= ~b[b.size()-1];
    endtask
endmodule

/* test/tb_top.sv */
// Self-checking bench for the mesh node command handler
// Assumes the host model drives serial input and takes replies
`timescale 1ns/100ps
module tb_top;
    import mnh_pkg::*;
    logic        aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
    logic        arvalid = 0, rready = 0, bvalid, awready, wready, arready, rvalid;
    logic        ser_valid, tx_ready, tx_valid, data_valid, data_end, reset_req;
    logic        net_valid = 0, net_last = 0;
    logic [3:0]  wstrb = 4'hF;
    logic [7:0]  net_byte = 0, query_code;
    logic [11:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata;
    logic [1:0]  bresp, rresp;
    logic [7:0]  ser_byte, tx_byte, pwm_duty, tag;
    logic [7:0]  expq[$], pk[$];
    int          failures = 0, comparisons = 0, dv = 0, de = 0, pulses = 0;
    int unsigned seed = 89;
    localparam logic [7:0] code[5] = '{C_PWM, C_PWM, 8'h04, C_RST, C_QLO};
    localparam logic [7:0] d1[5]   = '{8'h32, 8'h65, 8'h00, 8'h00, 8'h00};
    localparam logic [7:0] det[5]  = '{EVT_ACK, EVT_NAK, EVT_NAK, EVT_ACK, EVT_ACK};
    localparam logic [7:0] rsn[5]  = '{RSN_NONE, RSN_RANGE, RSN_CODE, RSN_NONE, RSN_NONE};
    always #2 aclk = ~aclk;
    mnh_node_cmd #(.MS_CYCLES(8)) dut_u (
        .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
        .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
        .rvalid, .rready, .ser_valid, .ser_byte, .net_valid, .net_byte,
        .net_last, .tx_valid, .tx_byte, .tx_ready, .data_valid, .data_byte(),
        .data_end, .gpio_out(), .gpio_oe(), .pwm_duty, .cfg_mode_req(), .reset_req,
        .query_req(), .query_code
    );
    mnh_host_model hm (.aclk, .ser_valid, .ser_byte, .tx_ready);
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] s, input logic [31:0] e);
        comparisons++;
        if (s !== e) begin
            failures++;
            $display("BAD %0t got %h want %h", $time, s, e);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
        logic aw_ok, w_ok;
        aw_ok = 1'b0;
        w_ok  = 1'b0;
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge aclk);
            if (awvalid && awready) begin
                aw_ok = 1'b1;
                awvalid <= 1'b0;
            end
            if (wvalid && wready) begin
                w_ok = 1'b1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (!bvalid);
        bready  <= 1'b0;
        check(bresp, r);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] r);
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        rready  <= 1'b1;
        do @(posedge aclk); while (!rvalid);
        rready  <= 1'b0;
        check(rdata, e);
        check(rresp, r);
    endtask
    function automatic logic [7:0] rnd8();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction
    // Expected 20-byte event reply for the current tag
    task automatic note(input logic [7:0] dt, input logic [7:0] rs, input logic [7:0] nb);
        expq.push_back(RPL_LEN);
        expq.push_back(nb);
        repeat (14) expq.push_back(8'h00);
        expq.push_back(PT_EVT);
        expq.push_back(dt);
        expq.push_back(tag);
        expq.push_back(rs);
    endtask
    task automatic drain();
        int k;
        k = 0;
        while (expq.size() > 0 && k < 500) begin
            @(posedge aclk);
            k++;
        end
        repeat (4) @(posedge aclk);
        check(expq.size(), 32'h0);
    endtask
    // Mesh side command bytes, last byte flagged
    task automatic net_send(input logic [7:0] b[$]);
        foreach (b[i]) begin
            @(posedge aclk);
            net_valid <= 1'b1;
            net_byte  <= b[i];
            net_last  <= (i == b.size() - 1);
        end
        @(posedge aclk);
        net_valid <= 1'b0;
        net_last  <= 1'b0;
    endtask
    task automatic close_out();
        $display("failures %0d comparisons %0d", failures, comparisons);
        if (failures == 0 && comparisons > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Reply monitor against noted bytes
    always @(posedge aclk) begin
        if (data_valid) dv++;
        if (data_end) de++;
        if (reset_req) pulses++;
        if (tx_valid && tx_ready) begin
            if (expq.size() == 0) check(tx_byte, 32'h1FF);
            else check(tx_byte, expq.pop_front());
        end
    end
    initial begin
        repeat (20000) @(posedge aclk);
        failures++;
        close_out();
    end
    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        rd(A_OUT, 32'h0, RESP_OK);
        rd(12'h300, 32'h0, RESP_ERR);
        wr(A_STAT, 32'h1, RESP_ERR);
        wr(A_CTRL, 32'h5, RESP_OK);
        wr(12'h180, 32'h1, RESP_OK);
        rd(A_CTRL, 32'h5, RESP_OK);
        foreach (code[i]) begin
            tag = rnd8();
            note(det[i], rsn[i], 8'h00);
            pk = {LEN_CTRL, 8'h01, 8'h02, 8'h03, 8'h04, tag, PT_CMD, code[i], d1[i], 8'h00};
            hm.send(pk);
            drain();
            check(pwm_duty, 32'h32);
        end
        check(query_code, C_QLO);
        check(pulses, 32'h1);
        // Configuration write: GPIO 0 becomes an output
        tag = rnd8();
        note(EVT_ACK, RSN_NONE, 8'h00);
        pk = {LEN_CFG, 8'h01, 8'h02, 8'h03, 8'h04, tag, PT_CMD, C_CFGW, CA_GPIO, FN_OUT};
        repeat (30) pk.push_back(8'h00);
        hm.send(pk);
        drain();
        rd(A_OUT, 32'h0001_3200, RESP_OK);
        pk = {LEN_CTRL, 8'h01, 8'h02, 8'h03, 8'h04, 8'h80, PT_CMD, C_PWM, 8'h09};
        hm.send(pk);
        repeat (100) @(posedge aclk);
        check(pwm_duty, 32'h32);
        rd(A_STAT, 32'h0000_0100, RESP_OK);
        // Remote role with reply, member of group 7
        wr(A_CTRL, 32'h2, RESP_OK);
        wr(12'h140, 32'h7, RESP_OK);
        pk = {};
        repeat (DATA_MAX + 2) pk.push_back(rnd8());
        hm.send(pk);
        repeat (40) @(posedge aclk);
        check(dv, DATA_MAX + 2);
        check(de, 32'h2);
        tag = rnd8() & 8'h7F;
        pk = {LEN_CTRL, ALL1, ALL1, ALL1, ALL1, tag, PT_CMD, C_PWM, 8'h14, 8'h00};
        net_send(pk);
        repeat (30) @(posedge aclk);
        check(pwm_duty, 32'h14);
        tag = rnd8() | 8'h80;
        note(EVT_ACK, RSN_NONE, 8'h00);
        pk = {LEN_CTRL, ALL1, ALL1, ALL1, 8'h07, tag, PT_CMD, C_PWM, 8'h28, 8'h00};
        net_send(pk);
        drain();
        check(pwm_duty, 32'h28);
        // Network identity set: channel change must be refused
        wr(12'h120, 32'h1, RESP_OK);
        tag = rnd8();
        note(EVT_NAK, RSN_LOCK, 8'h01);
        pk = {LEN_CFG, 8'h00, 8'h00, 8'h00, 8'h00, tag, PT_CMD, C_CFGW, CA_CHAN, 8'h05};
        repeat (30) pk.push_back(8'h00);
        net_send(pk);
        drain();
        rd(12'h104, 32'h0, RESP_OK);
        close_out();
    end
endmodule
